// ---- verilog/csp_pkg.sv ----
// constants for the correction serial port
// assumes a 100 MHz system clock sampling the external shift clock
// ******************************************************************
// ******************************************************************
package csp_pkg;
    localparam int  CSP_WIDTH       = 216;
    localparam int  CSP_CMN_LO      = 199;
    localparam int  CSP_CMN_W       = 17;
    localparam int  CSP_CLK_MHZ     = 100;
    localparam int  CSP_IDLE_MS     = 3;
    localparam int  CSP_IDLE_MAX_MS = 7;
    // least idle time, exact clk count for 3 ms; well inside the 7 ms ceiling
    localparam int  CSP_IDLE_CYC    = CSP_IDLE_MS * CSP_CLK_MHZ * 1000;
    localparam int  CSP_CNT_W       = 24;
    localparam logic [1:0] CSP_SYNC_RST = 2'h0;
endpackage

// ---- verilog/csp_latch.sv ----
// holding latch for the correction data, registered read-out
// assumes load strobe comes from the same clock domain
`timescale 1ns/1ps
module csp_latch #(
    parameter int W = 216
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         load,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dout <= '0;
        end else if (load) begin
            dout <= din;
        end
    end
endmodule

// ---- verilog/csp_top.sv ----
// correction serial port: shift register, serial out, idle auto-latch
// assumes shift clock and serial input are asynchronous pins
// assumes the common-port load strobe is a one-cycle clk-domain pulse
`timescale 1ns/1ps
module csp_top
    import csp_pkg::*;
#(
    parameter int WIDTH    = csp_pkg::CSP_WIDTH,
    parameter int IDLE_CYC = csp_pkg::CSP_IDLE_CYC
) (
    input  wire logic                             clk,
    input  wire logic                             resetn,
    input  wire logic                             correction_shift_clock,
    input  wire logic                             correction_serial_in,
    input  wire logic                             cmn_load,
    input  wire logic [csp_pkg::CSP_CMN_W-1:0]    cmn_bits,
    output logic                                  correction_serial_out,
    output logic      [WIDTH-1:0]                 correction_latch,
    output logic                                  latch_pulse
);
    import csp_pkg::*;

    // ******************************************************************
    // types and helpers
    // ******************************************************************
    // quiet: no shift edge since the last copy; timing: gap being timed
    typedef enum logic {
        QUIET,
        TIMING
    } csp_idle_state_type;

    // one shift step: the new bit enters at the bottom
    function automatic logic [WIDTH-1:0] shift_step(
        input logic [WIDTH-1:0] cur,
        input logic             din
    );
        shift_step = {cur[WIDTH-2:0], din};
    endfunction

    // end of the idle gap: the copy is due on the next edge
    function automatic logic gap_done(
        input logic [CSP_CNT_W-1:0] cnt
    );
        gap_done = (cnt == CSP_CNT_W'(IDLE_CYC - 1));
    endfunction

    // ******************************************************************
    // declarations
    // ******************************************************************
    logic [1:0]           sck_sync_q;
    logic [1:0]           sin_sync_q;
    logic                 sck_prev_q;
    logic                 rise;
    logic                 cmn_take;
    logic [WIDTH-1:0]     shreg_q;
    logic [WIDTH-1:0]     shreg_next;
    logic [CSP_CNT_W-1:0] idle_q;
    csp_idle_state_type   state_q;
    logic                 load_go;

    // ******************************************************************
    // pin synchronisers
    // ******************************************************************
    // two flops per pin; the shift clock must stay high and low
    // for more than one clk period or edges are lost
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_sync_q <= CSP_SYNC_RST;
        end else begin
            sck_sync_q <= {sck_sync_q[0], correction_shift_clock};
        end
    end

    // data pin runs through the same depth, so it lines up with the edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sin_sync_q <= CSP_SYNC_RST;
        end else begin
            sin_sync_q <= {sin_sync_q[0], correction_serial_in};
        end
    end

    // ******************************************************************
    // edge detect
    // ******************************************************************
    // reset level matches the idle low pin, so no false edge after reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= sck_sync_q[1];
        end
    end

    assign rise = sck_sync_q[1] & ~sck_prev_q;

    // a common-port load in the cycle of a shift edge is dropped
    assign cmn_take = cmn_load & ~rise;

    // ******************************************************************
    // shift register, own port apart from grayscale path
    // ******************************************************************
    assign shreg_next = shift_step(shreg_q, sin_sync_q[1]);

    // a common-port load lands in the same register; a shift edge wins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shreg_q <= '0;
        end else if (rise) begin
            shreg_q <= shreg_next;
        end else if (cmn_take) begin
            shreg_q[CSP_CMN_W-1:0] <= cmn_bits;
        end
    end

    // ******************************************************************
    // serial output
    // ******************************************************************
    // a common-port load only touches the low bits, so the top bit holds
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            correction_serial_out <= 1'b0;
        end else if (rise) begin
            correction_serial_out <= shreg_next[WIDTH-1];
        end
    end

    // ******************************************************************
    // idle timer and auto latch
    // ******************************************************************
    // copy timed at the shortest gap; the window's far end is never met
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= QUIET;
        end else begin
            unique case (state_q)
                QUIET: begin
                    if (rise) begin
                        state_q <= TIMING;
                    end
                end
                TIMING: begin
                    if (load_go) begin
                        state_q <= QUIET;
                    end
                end
            endcase
        end
    end

    // every shift edge restarts the count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_q <= '0;
        end else if (rise) begin
            idle_q <= '0;
        end else if (state_q == TIMING && !load_go) begin
            idle_q <= idle_q + 1'b1;
        end
    end

    assign load_go = (state_q == TIMING) && !rise
                     && gap_done(idle_q);

    // ******************************************************************
    // copy strobe
    // ******************************************************************
    // rises on the same edge that loads the latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latch_pulse <= 1'b0;
        end else begin
            latch_pulse <= load_go;
        end
    end

    // ******************************************************************
    // holding latch
    // ******************************************************************
    csp_latch #(
        .W (WIDTH)
    ) u_latch (
        .clk    (clk),
        .resetn (resetn),
        .load   (load_go),
        .din    (shreg_q),
        .dout   (correction_latch)
    );
endmodule

// ---- tb/csp_ctl.sv ----
// controller model: serial clock and data at 125 ns period
// assumes the bench calls put per bit and gap after each frame
`timescale 1ns/1ps
module csp_ctl (
    output logic sck,
    output logic sin
);
    initial begin
        sck = 1'h0;
        sin = 1'h0;
    end
    // data set while clock low, held over the rising edge
    task automatic put(input logic b);
        sin = b;
        #62.5 sck = 1'h1;
        #62.5 sck = 1'h0;
    endtask
    // clock stands still; released data line must not look held
    task automatic gap();
        sin = ~sin;
    endtask
endmodule

// ---- tb/csp_chk.sv ----
// checker on csp_top ports; helper counter times the idle gap
`timescale 1ns/1ps
module csp_chk
    import csp_pkg::*;
#(parameter int WIDTH = 216, parameter int IDLE_CYC = 50) (
    input wire logic clk, resetn, correction_shift_clock,
    input wire logic correction_serial_in, cmn_load, latch_pulse,
    input wire logic [CSP_CMN_W-1:0] cmn_bits,
    input wire logic correction_serial_out,
    input wire logic [WIDTH-1:0] correction_latch
);
    int   cnt, n;
    logic e;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= IDLE_CYC + 20;
            n   <= 0;
            e   <= 1'h0;
        end else if ($rose(correction_shift_clock)) begin
            cnt <= 0;
            n   <= 0;
            e   <= 1'h1;
        end else begin
            cnt <= (cnt < IDLE_CYC + 20) ? cnt + 1 : cnt;
            n   <= n + int'(latch_pulse);
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_pulse; latch_pulse ##1 !latch_pulse; endsequence
    AST_PULSE_ONE: assert property (latch_pulse |-> s_pulse)
        else $error("latch pulse longer than one cycle");
    AST_LATCH_WIN: assert property (latch_pulse |->
        cnt > IDLE_CYC && cnt < IDLE_CYC + 9) else $error("latch timing");
    AST_LATCH_PULSE: assert property ($changed(correction_latch) |->
        latch_pulse) else $error("latch change without pulse");
    AST_LATCH_HOLD: assert property (latch_pulse |=>
        $stable(correction_latch)) else $error("latch moved after pulse");
    AST_ONE_COPY: assert property (latch_pulse |-> n == 0)
        else $error("second copy in one gap");
    AST_LATCH_DUE: assert property (e && cnt == IDLE_CYC + 12 |-> n == 1)
        else $error("no copy after idle gap");
    AST_SOUT_CAUSE: assert property ($changed(correction_serial_out) |->
        cnt < 7) else $error("serial out moved without shift edge");
    AST_CMN_QUIET: assert property (cmn_load && cnt > 8 |=>
        $stable(correction_serial_out)) else $error("common load moved out");
endmodule
bind csp_top csp_chk #(.WIDTH(WIDTH), .IDLE_CYC(IDLE_CYC)) i_chk(.*);

// ---- tb/tb_top.sv ----
// bench: random frames against a shift model, latch compare
// assumes csp_ctl drives the serial pins
`timescale 1ns/1ps
module tb_top;
    import csp_pkg::*;
    localparam int IC = 50;
    logic clk = 1'h0, resetn = 1'h0, cmn_load = 1'h0, sck, sin, sout, lp;
    logic [CSP_CMN_W-1:0] cmn_bits = '0;
    logic [CSP_WIDTH-1:0] lat, m = '0;
    int   fails = 0, checks_done = 0, k;
    always #5 clk = ~clk;
    csp_ctl i_ctl(.sck(sck), .sin(sin));
    csp_top #(.IDLE_CYC(IC)) i_dut(.clk(clk), .resetn(resetn),
        .correction_shift_clock(sck), .correction_serial_in(sin),
        .cmn_load(cmn_load), .cmn_bits(cmn_bits),
        .correction_serial_out(sout), .correction_latch(lat),
        .latch_pulse(lp));
    task automatic chk(input logic [CSP_WIDTH-1:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic send(input int n);
        logic b;
        for (int i = 0; i < n; i++) begin
            b = 1'($urandom);
            i_ctl.put(b);
            m = {m[CSP_WIDTH-2:0], b};
            chk(sout, m[CSP_WIDTH-1]);
        end
        i_ctl.gap();
        for (k = 0; k < IC + 40 && lp !== 1'h1; k++) begin
            @(posedge clk);
            #1;
        end
        if (k == IC + 40) begin
            fails++;
            summarize();
        end
        chk(lat, m);
    endtask
    initial begin
        void'($urandom(61));
        repeat (16) @(posedge clk);
        #1 resetn = 1'h1;
        chk(lat, '0);
        send(CSP_WIDTH);
        send(5);
        k = 0;
        repeat (IC + 20) begin
            @(posedge clk);
            #1;
            k += int'(lp);
        end
        chk(k, 0);
        cmn_bits = CSP_CMN_W'($urandom);
        cmn_load = 1'h1;
        m[CSP_CMN_W-1:0] = cmn_bits;
        @(posedge clk) #1 cmn_load = 1'h0;
        send(1);
        summarize();
    end
endmodule
